// ==== edge_sync.v ====
// Two flop synchroniser with edge detection on the synchronised level
// Assumes input from another clock domain
`timescale 1ns/1ps
module edge_sync #(
	parameter RESET_VAL = 1'b0
) (
	input wire clock_i,
	input wire rst_i,
	input wire async_i,
	output wire level_o,
	output wire rise_o,
	output wire fall_o
);
	reg meta_r;
	reg sync_r;
	reg prev_r;
	always @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			meta_r <= RESET_VAL;
			sync_r <= RESET_VAL;
			prev_r <= RESET_VAL;
		end else begin
			meta_r <= async_i;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end
	assign level_o = sync_r;
	assign rise_o = sync_r & ~prev_r;
	assign fall_o = ~sync_r & prev_r;
endmodule // edge_sync

// ==== serial_ctrl_model.sv ====
// Controller model on the three load lines
// Assumes the bench calls frame
`timescale 1ns/1ps
module serial_ctrl_model (
	output logic enable_n_o = 1'b1,
	output logic sclk_o = 1'b0,
	output logic sdata_o = 1'b0
);
	task automatic shift(input logic b);
		sdata_o = b;
		#62.5 sclk_o = 1'b1;
		#31.25 sdata_o = ~b; // Bit gone once hold ends
		#31.25 sclk_o = 1'b0;
	endtask
	task automatic frame(input logic [1:0] a, input logic [31:0] d, input int n);
		enable_n_o = 1'b0;
		#250 shift(a[1]);
		shift(a[0]);
		for (int i = n - 1; i >= 0; i--) shift(d[i]);
		#250 enable_n_o = 1'b1;
		#250 shift(d[0]); // Unused edge while enable is high
		#250;
	endtask
endmodule // serial_ctrl_model

// ==== synth_load_consts.vh ====
// Constants for the serial load port of the frequency synthesizer
// Assumes inclusion by bare name from the design files
`ifndef SYNTH_LOAD_CONSTS_VH
`define SYNTH_LOAD_CONSTS_VH
`define SHIFT_WIDTH 19
`define ADDR_BITS 2
`define ADDR_MATCH 2'h3
`define POS_OUT19 18
`define POS_OUT18 17
`define POS_REF17 16
`define POS_REF16 15
`define POS_AMFM 14
`define DIV_WIDTH 14
`define LATCH_RESET 19'h00000
`define REF_20K 2'h3
`define REF_10K 2'h2
`define REF_9K 2'h1
`define REF_1K 2'h0
`endif

// ==== synth_load_sva.sv ====
// Load port checker
// Assumes bind by name
`timescale 1ns/1ps
module synth_load_sva #(parameter DIV_WIDTH = 14) (
	input wire clock_i,
	input wire rst_i,
	input wire enable_n_i,
	input wire load_done_o,
	input wire amfm_sel_o,
	input wire fm_path_en_o,
	input wire [DIV_WIDTH-1:0] div_n_o,
	input wire [DIV_WIDTH:0] div_ratio_o,
	input wire [1:0] ref_sel_o,
	input wire ref_20k_o,
	input wire gp19_o,
	input wire gp19_oe_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);
	sequence low_run; !enable_n_i [*8]; endsequence
	a_ratio_sum: assert property (div_ratio_o == div_n_o + 1'b1) else $error("ratio");
	a_ref_top: assert property (ref_20k_o == (ref_sel_o == 2'h3)) else $error("ref");
	a_fm_path: assert property (fm_path_en_o == amfm_sel_o) else $error("path");
	a_gp_low: assert property (gp19_o == 1'b0) else $error("gp");
	a_latch_hold: assert property (low_run |-> $stable(div_n_o) && !load_done_o)
		else $error("hold");
	a_done_pulse: assert property (load_done_o |=> !load_done_o) else $error("pulse");
	a_gp_update: assert property ($changed(gp19_oe_o) |-> load_done_o) else $error("gp");
	a_div_update: assert property ($changed(div_n_o) |-> $past(load_done_o)) else $error("div");
endmodule // synth_load_sva
bind synth_serial_load_latch synth_load_sva #(.DIV_WIDTH(DIV_WIDTH)) u_sva (
	.clock_i(clock_i),
	.rst_i(rst_i),
	.enable_n_i(enable_n_i),
	.load_done_o(load_done_o),
	.amfm_sel_o(amfm_sel_o),
	.fm_path_en_o(fm_path_en_o),
	.div_n_o(div_n_o),
	.div_ratio_o(div_ratio_o),
	.ref_sel_o(ref_sel_o),
	.ref_20k_o(ref_20k_o),
	.gp19_o(gp19_o),
	.gp19_oe_o(gp19_oe_o)
);

// ==== synth_serial_load_latch.v ====
// Three-wire serial load port: address check, 19-bit shift register, data latches
// Assumes enable, clock and data come from an external controller, asynchronous to clock_i
`timescale 1ns/1ps
`include "synth_load_consts.vh"

module synth_serial_load_latch #(
	parameter SHIFT_WIDTH = `SHIFT_WIDTH,
	parameter DIV_WIDTH = `DIV_WIDTH
) (
	input wire clock_i,
	input wire rst_i,
	input wire enable_n_i,
	input wire sclk_i,
	input wire sdata_i,
	output reg [DIV_WIDTH-1:0] div_n_o,
	output reg [DIV_WIDTH:0] div_ratio_o,
	output reg amfm_sel_o,
	output reg [1:0] ref_sel_o,
	output reg ref_20k_o,
	output reg ref_10k_o,
	output reg ref_9k_o,
	output reg ref_1k_o,
	output reg fm_path_en_o,
	output reg am_path_en_o,
	output wire gp18_o,
	output wire gp18_oe_o,
	output wire gp19_o,
	output wire gp19_oe_o,
	output reg load_done_o
);
	// ****************************************
	// Input synchronisation
	// ****************************************
	wire en_n_lvl;
	wire en_rise;
	wire en_fall;
	wire sclk_rise;
	wire data_lvl;

	edge_sync #(.RESET_VAL(1'b1)) u_en_sync (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.async_i(enable_n_i),
		.level_o(en_n_lvl),
		.rise_o(en_rise),
		.fall_o(en_fall)
	);

	edge_sync #(.RESET_VAL(1'b0)) u_clk_sync (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.async_i(sclk_i),
		.level_o(),
		.rise_o(sclk_rise),
		.fall_o()
	);

	edge_sync #(.RESET_VAL(1'b0)) u_dat_sync (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.async_i(sdata_i),
		.level_o(data_lvl),
		.rise_o(),
		.fall_o()
	);

	// ****************************************
	// Frame state machine
	// ****************************************
	localparam ST_IDLE = 2'h0;
	localparam ST_ADDR = 2'h1;
	localparam ST_DATA = 2'h2;
	localparam ST_SKIP = 2'h3;

	reg [1:0] state_r;
	reg [1:0] state_nxt;
	reg [1:0] addr_cnt_r;
	reg [1:0] addr_cnt_nxt;
	reg [1:0] addr_r;
	reg [1:0] addr_nxt;
	reg [SHIFT_WIDTH-1:0] shift_r;
	reg [SHIFT_WIDTH-1:0] shift_nxt;
	reg latch_en;

	// Data enters at bit 0, so the last bit received ends up at bit 0 of shift_r
	always @* begin
		state_nxt = state_r;
		addr_cnt_nxt = addr_cnt_r;
		addr_nxt = addr_r;
		shift_nxt = shift_r;
		latch_en = 1'b0;
		case (state_r)
			ST_IDLE: begin
				if (en_fall) begin
					state_nxt = ST_ADDR;
					addr_cnt_nxt = 2'h0;
				end
			end
			ST_ADDR: begin
				if (en_rise) begin
					state_nxt = ST_IDLE;
				end else if (sclk_rise) begin
					addr_nxt = {addr_r[0], data_lvl};
					addr_cnt_nxt = addr_cnt_r + 2'h1;
					// A mismatch parks the frame in ST_SKIP until enable rises
					if (addr_cnt_r == 2'h1) begin
						if ({addr_r[0], data_lvl} == `ADDR_MATCH)
							state_nxt = ST_DATA;
						else
							state_nxt = ST_SKIP;
					end
				end
			end
			ST_DATA: begin
				if (en_rise) begin
					state_nxt = ST_IDLE;
					latch_en = 1'b1;
				end else if (sclk_rise) begin
					shift_nxt = {shift_r[SHIFT_WIDTH-2:0], data_lvl};
				end
			end
			ST_SKIP: begin
				if (en_rise)
					state_nxt = ST_IDLE;
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
		// Enable high blocks all entry regardless of state
		if (en_n_lvl && state_r != ST_IDLE && !en_rise)
			state_nxt = ST_IDLE;
	end

	always @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			state_r <= ST_IDLE;
			addr_cnt_r <= 2'h0;
			addr_r <= 2'h0;
			shift_r <= `LATCH_RESET;
		end else begin
			state_r <= state_nxt;
			addr_cnt_r <= addr_cnt_nxt;
			addr_r <= addr_nxt;
			shift_r <= shift_nxt;
		end
	end

	// ****************************************
	// Data latches and decoded outputs
	// ****************************************
	reg [SHIFT_WIDTH-1:0] latch_r;

	// Reversed order: latch bit k holds the (19-k)th to last bit
	function [SHIFT_WIDTH-1:0] reorder;
		input [SHIFT_WIDTH-1:0] s;
		integer i;
		begin
			for (i = 0; i < SHIFT_WIDTH; i = i + 1)
				reorder[i] = s[SHIFT_WIDTH-1-i];
		end
	endfunction

	// Pulses with the latch update; the registered decoded outputs follow one clock later, gp18_oe_o and gp19_oe_o in the same clock
	always @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			latch_r <= `LATCH_RESET;
			load_done_o <= 1'b0;
		end else begin
			load_done_o <= latch_en;
			if (latch_en)
				latch_r <= reorder(shift_r);
		end
	end

	// Reference pair ordered bit 16 then bit 17, the same order as ref_sel_o
	wire [1:0] ref_bits = {latch_r[`POS_REF16], latch_r[`POS_REF17]};
	wire amfm_bit = latch_r[`POS_AMFM];

	always @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			div_n_o <= {DIV_WIDTH{1'b0}};
			div_ratio_o <= {{DIV_WIDTH{1'b0}}, 1'b1};
			amfm_sel_o <= 1'b0;
			ref_sel_o <= `REF_1K;
			ref_20k_o <= 1'b0;
			ref_10k_o <= 1'b0;
			ref_9k_o <= 1'b0;
			ref_1k_o <= 1'b1;
			fm_path_en_o <= 1'b0;
			am_path_en_o <= 1'b1;
		end else begin
			div_n_o <= latch_r[DIV_WIDTH-1:0];
			div_ratio_o <= {1'b0, latch_r[DIV_WIDTH-1:0]} + {{DIV_WIDTH{1'b0}}, 1'b1};
			amfm_sel_o <= amfm_bit;
			ref_sel_o <= ref_bits;
			ref_20k_o <= ref_bits == `REF_20K;
			ref_10k_o <= ref_bits == `REF_10K;
			ref_9k_o <= ref_bits == `REF_9K;
			ref_1k_o <= ref_bits == `REF_1K;
			fm_path_en_o <= amfm_bit;
			am_path_en_o <= ~amfm_bit;
		end
	end

	// Open collector: pin pulled low when the latch bit is zero
	assign gp19_o = 1'b0;
	assign gp19_oe_o = ~latch_r[`POS_OUT19];
	assign gp18_o = 1'b0;
	assign gp18_oe_o = ~latch_r[`POS_OUT18];
endmodule // synth_serial_load_latch

// ==== synth_serial_load_latch_bench.sv ====
// Load port bench
// Assumes the controller model
`timescale 1ns/1ps
module synth_serial_load_latch_bench;
	logic clock_i = 1'b0, rst_i = 1'b1;
	wire enable_n_i, sclk_i, sdata_i, amfm_sel_o, ref_20k_o, ref_10k_o, ref_9k_o, ref_1k_o;
	wire fm_path_en_o, am_path_en_o, gp18_o, gp18_oe_o, gp19_o, gp19_oe_o, load_done_o;
	wire [13:0] div_n_o;
	wire [14:0] div_ratio_o;
	wire [1:0] ref_sel_o;
	int num_errors = 0, tests_run = 0, cycles = 0, n, loads = 0, loads_exp = 0;
	logic [31:0] seed = 32'h58, d;
	logic [13:0] n_exp;
	logic [1:0] a;
	logic q[$];
	synth_serial_load_latch u_synth_serial_load_latch (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.enable_n_i(enable_n_i),
		.sclk_i(sclk_i),
		.sdata_i(sdata_i),
		.div_n_o(div_n_o),
		.div_ratio_o(div_ratio_o),
		.amfm_sel_o(amfm_sel_o),
		.ref_sel_o(ref_sel_o),
		.ref_20k_o(ref_20k_o),
		.ref_10k_o(ref_10k_o),
		.ref_9k_o(ref_9k_o),
		.ref_1k_o(ref_1k_o),
		.fm_path_en_o(fm_path_en_o),
		.am_path_en_o(am_path_en_o),
		.gp18_o(gp18_o),
		.gp18_oe_o(gp18_oe_o),
		.gp19_o(gp19_o),
		.gp19_oe_o(gp19_oe_o),
		.load_done_o(load_done_o)
	);
	serial_ctrl_model u_ctrl (.enable_n_o(enable_n_i), .sclk_o(sclk_i), .sdata_o(sdata_i));
	initial forever #5 clock_i = ~clock_i;
	always @(posedge clock_i) if (++cycles == 30000) begin
		num_errors++;
		give_verdict();
	end
	always @(posedge clock_i) if (load_done_o === 1'b1) loads++;
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(string s, logic [31:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", s, exp, seen);
		end
	endtask
	task automatic give_verdict();
		$display("%0d checks %0d errors", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (19) q.push_back(1'b0);
		repeat (12) @(posedge clock_i);
		#1 rst_i = 1'b0;
		for (int f = 0; f < 20; f++) begin
			d = rnd();
			a = (f % 4 == 3) ? f[3:2] : 2'h3;
			n = (f % 5 == 4) ? 6 : 19 + d[29:27];
			u_ctrl.frame(a, d, n);
			if (a == 2'h3) for (int i = n - 1; i >= 0; i--) q.push_back(d[i]);
			while (q.size() > 19) q.pop_front();
			for (int i = 0; i < 14; i++) n_exp[i] = q[i];
			chk("out", {div_n_o, amfm_sel_o, ref_sel_o, fm_path_en_o, gp19_oe_o, gp18_oe_o},
				{n_exp, q[14], q[15], q[16], q[14], !q[18], !q[17]});
			if (a == 2'h3) loads_exp++;
			chk("loads", loads, loads_exp);
			chk("ratio", div_ratio_o, {1'b0, n_exp} + 15'h1);
			chk("refs", {ref_20k_o, ref_10k_o, ref_9k_o, ref_1k_o}, 4'h1 << {q[15], q[16]});
			chk("am gp", {am_path_en_o, gp19_o, gp18_o}, {!q[14], 2'h0});
		end
		give_verdict();
	end
endmodule // synth_serial_load_latch_bench
